// file: pdt_pkg.sv
// Purpose: Shared constants and types of the programmable delay timer.
// Assumes: One 50 MHz system clock; the time base is derived from it.
// Notes: The low-pulse minimum is kept in ns next to its cycle count; the period is in cycles only.
package pdt_pkg;

   localparam int CLK_PERIOD_NS = 20;

   // The low pulse on the time-base node must last longer than this.
   localparam int TB_LOW_MIN_NS = 500;
   // Strictly longer than the minimum, so one cycle above the exact ratio.
   localparam int TB_LOW_CYCLES = TB_LOW_MIN_NS / CLK_PERIOD_NS + 1;

   // Default time-base period in clock cycles (one count per period).
   localparam int TB_PERIOD_CYCLES = 1000;

   localparam int COUNT_W = 8;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 8'hff;
   localparam logic [COUNT_W-1:0] COUNT_STEP = 8'h01;

   // Bit positions of the synchronised pin inputs.
   localparam int SYN_CYCLE_START_INPUT = 0;
   localparam int SYN_RST = 1;
   localparam int SYN_NODE = 2;
   localparam int SYN_OSCEN = 3;
   localparam int SYN_W = 4;
   // Trigger and reset idle low; node idles high, oscillator enabled.
   localparam logic [SYN_W-1:0] SYN_RESET = 4'hc;

   typedef enum logic {PDT_IDLE, PDT_RUN} pdt_state_t;

endpackage

// file: pdt_tb_if.sv
// Purpose: Link between the control logic and the time-base oscillator.
// Assumes: Both ends run on the same clock.
// Notes: pullLow is registered inside the oscillator.
interface pdt_tb_if;
   logic run;
   logic oscEnable;
   logic pullLow;

   modport osc (input run, input oscEnable, output pullLow);
   modport ctrl (output run, output oscEnable, input pullLow);
endinterface

// file: pdt_sync.sv
// Purpose: Two-stage synchroniser with edge detection for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: Edge pulses are one clock wide and combinational from flops.
module pdt_sync #(
   parameter int W = pdt_pkg::SYN_W,
   parameter logic [W-1:0] RESET_VAL = pdt_pkg::SYN_RESET
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   logic [W-1:0] meta_q, meta_d;
   logic [W-1:0] sync_q, sync_d;
   logic [W-1:0] prev_q, prev_d;

   // The first stage feeds only the second stage.
   always_comb
   begin
      meta_d = pinIn;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
         prev_q <= RESET_VAL;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   rise_single_a: assert property (|rise |=>
      (rise & $past(rise)) == '0)
      else $error("Edge pulse lasted more than one cycle.");

endmodule

// file: pdt_timebase.sv
// Purpose: Time-base oscillator that pulls the time-base node low once a
// period while a timing cycle runs.
// Assumes: PERIOD exceeds the low pulse width.
// Notes: The first low pulse comes one full period after the start.
module pdt_timebase #(
   parameter int PERIOD = pdt_pkg::TB_PERIOD_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   pdt_tb_if.osc tb
);

   // The phase runs up to PERIOD plus the pulse width minus one and then wraps to the
   // pulse width. The first fall then lands one whole period after the start,
   // and every later fall one period after the one before.
   localparam int PW = $clog2(PERIOD + pdt_pkg::TB_LOW_CYCLES);
   localparam logic [PW-1:0] LAST =
      PW'(PERIOD + pdt_pkg::TB_LOW_CYCLES - 1);
   localparam logic [PW-1:0] LOW_FROM = PW'(PERIOD);
   localparam logic [PW-1:0] WRAP_TO = PW'(pdt_pkg::TB_LOW_CYCLES);

   logic [PW-1:0] phase_q, phase_d;
   logic pullLow_q, pullLow_d;

   always_comb
   begin
      phase_d = '0;
      pullLow_d = 1'b0;
      // Stopped while idle, so the node is released high.
      if (tb.run && tb.oscEnable)
      begin
         phase_d = (phase_q == LAST) ? WRAP_TO : PW'(phase_q + 1'b1);
         pullLow_d = (phase_d >= LOW_FROM);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_q <= '0;
         pullLow_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         pullLow_q <= pullLow_d;
      end
   end

   assign tb.pullLow = pullLow_q;

   // Helper: length of the current low pulse.
   logic [PW-1:0] lowLen_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lowLen_q <= '0;
      else
         lowLen_q <= pullLow_q ? PW'(lowLen_q + 1'b1) : '0;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   low_width_a: assert property ($fell(pullLow_q) &&
      $past(tb.run) && $past(tb.oscEnable) |->
      lowLen_q == PW'(pdt_pkg::TB_LOW_CYCLES))
      else $error("Time-base low pulse has the wrong width.");

   stop_release_a: assert property (!tb.run |=> !pullLow_q)
      else $error("Time-base node pulled low while stopped.");

endmodule

// file: pdt_timer.sv
// Purpose: 8-bit programmable delay timer with open-collector weighted
// count outputs and an open-collector time-base node.
// Assumes: All pin inputs are asynchronous and pass two flip-flops.
// Notes: Open-collector pins drive low only; the bench resolves the wire.

// Overview of operation
// - After power-up, with no trigger or reset, count outputs are high.
// - Trigger rise starts oscillator and counter, drives outputs low.
// - While running, the counter counts one per time-base period.
// - Reset rising edge ends the cycle and returns to the reset state.
// - While running, further trigger edges are ignored.
// - Trigger and reset together: the trigger wins.
// - In reset state, oscillator stopped, counter disabled, outputs high.
// - With no feedback the counter runs freely until an external reset.
// - A lone output stays low for its binary weight in periods.
// - Time-base node high in reset, low pulse once a period when running.
// - Each time-base low pulse lasts longer than 500 ns.
// - Counter advances on each falling edge of the time-base node.
// - An external clock on the node is counted in place of the oscillator.
// - Counter stops while the node is held low from outside.
// - Outputs are open-collector and non-conducting in the reset state.
// - Joined outputs read low while any of them is low.
// - Cycle length is the sum of joined weights, 1 to 255 periods.
module pdt_timer #(
   parameter int TB_PERIOD = pdt_pkg::TB_PERIOD_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cycleStartIn,
   input wire logic resetIn,
   input wire logic timeBaseIn,
   output logic timeBaseOut,
   output logic timeBaseOe,
   input wire logic oscEnableIn,
   output logic [pdt_pkg::COUNT_W-1:0] weightedCountOut,
   output logic [pdt_pkg::COUNT_W-1:0] weightedCountOe,
   output logic cycleActive
);

   localparam int CW = pdt_pkg::COUNT_W;

   logic [pdt_pkg::SYN_W-1:0] pinLevel, pinRise, pinFall;
   logic trigRise, rstRise, nodeFall;

   pdt_tb_if tb ();

   pdt_sync #(
      .W(pdt_pkg::SYN_W),
      .RESET_VAL(pdt_pkg::SYN_RESET)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pinIn({oscEnableIn, timeBaseIn, resetIn, cycleStartIn}),
      .level(pinLevel),
      .rise(pinRise),
      .fall(pinFall)
   );

   assign trigRise = pinRise[pdt_pkg::SYN_CYCLE_START_INPUT];
   // Reset may come straight from the joined outputs for monostable use.
   assign rstRise = pinRise[pdt_pkg::SYN_RST];
   // The node is read back, so an outside clock or clamp acts on it too.
   assign nodeFall = pinFall[pdt_pkg::SYN_NODE];

   pdt_timebase #(
      .PERIOD(TB_PERIOD)
   ) u_timebase (
      .clk(clk),
      .rst_n(rst_n),
      .tb(tb.osc)
   );

   pdt_pkg::pdt_state_t state_q, state_d;
   logic [CW-1:0] count_q, count_d;
   logic [CW-1:0] countOe_q, countOe_d;

   always_comb
   begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         pdt_pkg::PDT_IDLE:
         begin
            // Reset alone in idle changes nothing.
            if (trigRise)
            begin
               state_d = pdt_pkg::PDT_RUN;
               count_d = pdt_pkg::COUNT_RESET;
            end
         end
         pdt_pkg::PDT_RUN:
         begin
            if (trigRise && rstRise)
            begin
               // Trigger wins: the cycle restarts from zero.
               count_d = pdt_pkg::COUNT_RESET;
            end
            else if (rstRise)
            begin
               state_d = pdt_pkg::PDT_IDLE;
               count_d = pdt_pkg::COUNT_RESET;
            end
            else if (nodeFall)
            begin
               // Wraps after 255 so a free-running cycle keeps going.
               count_d = CW'(count_q + pdt_pkg::COUNT_STEP);
            end
            // A lone trigger edge while running falls through unheeded.
         end
         default:
         begin
            state_d = pdt_pkg::PDT_IDLE;
            count_d = pdt_pkg::COUNT_RESET;
         end
      endcase
      // A bit conducts while it is zero, so output weight 2^i stays low for
      // 2^i periods; joined outputs form the programmed count.
      if (state_d == pdt_pkg::PDT_RUN)
         countOe_d = ~count_d;
      else
         countOe_d = '0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= pdt_pkg::PDT_IDLE;
         count_q <= pdt_pkg::COUNT_RESET;
         countOe_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         count_q <= count_d;
         countOe_q <= countOe_d;
      end
   end

   assign tb.run = (state_q == pdt_pkg::PDT_RUN);
   assign tb.oscEnable = pinLevel[pdt_pkg::SYN_OSCEN];

   // Both pins only ever sink, the pull-up gives the high level, so the
   // wired bus is low while any joined output conducts.
   assign weightedCountOut = '0;
   assign weightedCountOe = countOe_q;
   assign timeBaseOut = 1'b0;
   assign timeBaseOe = tb.pullLow;
   assign cycleActive = tb.run;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   idle_release_a: assert property (
      !cycleActive |-> weightedCountOe == '0)
      else $error("Count output conducting in the reset state.");

   idle_node_a: assert property (!cycleActive &&
      !$past(cycleActive) |-> !timeBaseOe)
      else $error("Time-base node driven while idle.");

   cycle_start_input_start_a: assert property (!cycleActive && trigRise |=>
      cycleActive && count_q == pdt_pkg::COUNT_RESET &&
      weightedCountOe == pdt_pkg::COUNT_ALL_ONES)
      else $error("Trigger did not start a cycle with all outputs low.");

   count_step_a: assert property (cycleActive && nodeFall &&
      !trigRise && !rstRise |=>
      count_q == CW'($past(count_q) + pdt_pkg::COUNT_STEP))
      else $error("Counter did not advance on a time-base fall.");

   reset_end_a: assert property (cycleActive && rstRise && !trigRise
      |=> !cycleActive && weightedCountOe == '0)
      else $error("Reset edge did not end the cycle.");

   cycle_start_input_ignored_a: assert property (cycleActive && trigRise &&
      !rstRise && !nodeFall |=> cycleActive && $stable(count_q))
      else $error("Trigger disturbed a running cycle.");

   cycle_start_input_wins_a: assert property (trigRise && rstRise |=>
      cycleActive && count_q == pdt_pkg::COUNT_RESET)
      else $error("Reset beat a simultaneous trigger.");

   free_run_a: assert property (cycleActive && !rstRise
      |=> cycleActive)
      else $error("Cycle ended without a reset edge.");

   out_weight_a: assert property (cycleActive |->
      weightedCountOe == ~count_q)
      else $error("Count outputs do not follow the count bits.");

   node_stall_a: assert property (cycleActive && !nodeFall
      && !trigRise && !rstRise |=> $stable(count_q))
      else $error("Counter moved without a time-base fall.");

   start_c: cover property (!cycleActive ##1 cycleActive);

   full_count_c: cover property (cycleActive &&
      count_q == pdt_pkg::COUNT_ALL_ONES);

   mono_end_c: cover property (cycleActive && rstRise ##1 !cycleActive);

   both_edges_c: cover property (trigRise && rstRise);

endmodule

// file: pdt_partner.sv
// Purpose: Far side of the timer: wired output bus, reset feed, time-base
// wire with optional external clock.
// Assumes: Both wires are pulled up; only sinking stages pull them low.
// Notes: The reset pin follows the bus in monostable use.
module pdt_partner (
   input wire logic [7:0] countOut,
   input wire logic [7:0] countOe,
   input wire logic [7:0] selectMask,
   input wire logic feedbackOn,
   input wire logic extResetReq,
   input wire logic tbOut,
   input wire logic tbOe,
   input wire logic extClkLow,
   output logic busLevel,
   output logic resetIn,
   output logic timeBaseIn
);
   // A released pin floats to the pull-up; any sinking joined pin wins.
   assign busLevel = &(((countOe & countOut) | ~countOe) | ~selectMask);
   // Closing the feedback switch ties the joined bus to the reset pin.
   assign resetIn = feedbackOn ? busLevel : extResetReq;
   assign timeBaseIn = (tbOe ? tbOut : 1'b1) & ~extClkLow;
endmodule

// file: programmable_delay_timer_test.sv
// Purpose: Self-checking bench of the programmable delay timer.
// Assumes: Short time-base period so that full counts run quickly.
// Notes: Inputs change on the falling clock edge only.
module programmable_delay_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 40;
   logic clk, rst_n, cycle_start_input, extRst, extClkLow, oscEn, feedbackOn;
   logic [7:0] mask, cOut, cOe;
   logic tbOut, tbOe, active, busLevel, resetIn, tbIn;
   int badCount, nCompared;

   pdt_timer #(.TB_PERIOD(P)) dut (.clk(clk), .rst_n(rst_n),
      .cycleStartIn(cycle_start_input), .resetIn(resetIn), .timeBaseIn(tbIn),
      .timeBaseOut(tbOut), .timeBaseOe(tbOe), .oscEnableIn(oscEn),
      .weightedCountOut(cOut), .weightedCountOe(cOe), .cycleActive(active));
   pdt_partner far (.countOut(cOut), .countOe(cOe), .selectMask(mask),
      .feedbackOn(feedbackOn), .extResetReq(extRst), .tbOut(tbOut),
      .tbOe(tbOe), .extClkLow(extClkLow), .busLevel(busLevel),
      .resetIn(resetIn), .timeBaseIn(tbIn));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic conclude();
      $display("Compared %0d, mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic checkEq(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
      nCompared++;
      if (got !== exp)
      begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic checkIn(input string what, input int lo, input int hi,
                          input int got);
      nCompared++;
      if (got < lo || got > hi)
      begin
         badCount++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi,
                  got);
      end
   endtask

   task automatic pulse(input bit isTrig, input bit both);
      @(negedge clk);
      if (isTrig || both) cycle_start_input = 1'b1;
      if (!isTrig || both) extRst = 1'b1;
      repeat (4) @(negedge clk);
      cycle_start_input = 1'b0;
      extRst = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic idleState();
      int seen;
      seen = 0;
      // Join every output so that the idle bus level means something.
      mask = 8'hff;
      repeat (2 * P)
      begin
         @(negedge clk);
         if (tbOe !== 1'b0) seen++;
      end
      checkEq("idle tb pulses", 8'h00, 8'(seen));
      checkEq("idle outputs oe", 8'h00, cOe);
      checkEq("idle active", 8'h00, {7'h00, active});
      checkEq("idle bus", 8'h01, {7'h00, busLevel});
   endtask

   // Monostable cycle; a second trigger in mid-cycle must not stretch it.
   task automatic mono(input logic [7:0] m);
      int len, n;
      n = int'(m) * P;
      @(negedge clk);
      mask = m;
      feedbackOn = 1'b1;
      pulse(1'b1, 1'b0);
      len = 0;
      while (busLevel === 1'b0 && len < 300 * P)
      begin
         len++;
         if (len == 3) cycle_start_input = 1'b1;
         if (len == 7) cycle_start_input = 1'b0;
         @(negedge clk);
      end
      // The bus was already low for three samples before the loop began.
      // Bus release trails the node fall by three clocks through the synchroniser and the counter.
      checkIn("cycle length", n, n + 4, len + 3);
      repeat (5) @(negedge clk);
      checkEq("self reset active", 8'h00, {7'h00, active});
      feedbackOn = 1'b0;
      mask = 8'h00;
   endtask

   task automatic freeRun();
      int w;
      pulse(1'b1, 1'b0);
      checkEq("start oe", 8'hff, cOe);
      repeat (5 * P + 4) @(negedge clk);
      checkEq("count after 5", ~8'h05, cOe);
      // Let the pulse under way finish, then time a whole one.
      for (w = 0; tbOe === 1'b1 && w < P; w++)
         @(negedge clk);
      for (w = 0; tbOe !== 1'b1 && w < P; w++)
         @(negedge clk);
      for (w = 0; tbOe === 1'b1 && w < P; w++)
         @(negedge clk);
      checkIn("tb low width", pdt_pkg::TB_LOW_CYCLES,
              pdt_pkg::TB_LOW_CYCLES, w);
      pulse(1'b0, 1'b0);
      checkEq("reset oe", 8'h00, cOe);
      checkEq("reset tb", 8'h00, {6'h00, tbOe, active});
   endtask

   task automatic bothAtOnce();
      pulse(1'b1, 1'b1);
      checkEq("both active", 8'h01, {7'h00, active});
      checkEq("both oe", 8'hff, cOe);
      // Let two counts pass, then hit both pins while running.
      repeat (2 * P + 10) @(negedge clk);
      checkEq("count before restart", ~8'h02, cOe);
      pulse(1'b1, 1'b1);
      checkEq("restart active", 8'h01, {7'h00, active});
      checkEq("restart oe", 8'hff, cOe);
      pulse(1'b0, 1'b0);
   endtask

   task automatic extClock();
      oscEn = 1'b0;
      pulse(1'b1, 1'b0);
      repeat (3)
      begin
         extClkLow = 1'b1;
         repeat (4) @(negedge clk);
         extClkLow = 1'b0;
         repeat (4) @(negedge clk);
      end
      checkEq("ext clock count", ~8'h03, cOe);
      // The clamp itself is one more falling edge; after that the running
      // oscillator must not move the count while the node is held low.
      extClkLow = 1'b1;
      repeat (4) @(negedge clk);
      oscEn = 1'b1;
      repeat (3 * P) @(negedge clk);
      checkEq("held low count", ~8'h04, cOe);
      oscEn = 1'b0;
      repeat (4) @(negedge clk);
      extClkLow = 1'b0;
      repeat (4) @(negedge clk);
      checkEq("release count", ~8'h04, cOe);
      pulse(1'b0, 1'b0);
      oscEn = 1'b1;
   endtask

   initial
   begin
      badCount = 0;
      nCompared = 0;
      rst_n = 1'b0;
      cycle_start_input = 1'b0;
      extRst = 1'b0;
      extClkLow = 1'b0;
      oscEn = 1'b1;
      feedbackOn = 1'b0;
      mask = 8'h00;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      idleState();
      mono(8'h01);
      mono(8'h20);
      mono(8'h31);
      mono(8'hff);
      freeRun();
      bothAtOnce();
      extClock();
      conclude();
   end

   // The whole sequence needs about 15000 cycles; allow ample margin.
   initial
   begin
      repeat (60000) @(posedge clk);
      badCount++;
      conclude();
   end
endmodule
